// ===== design/block_ram_single_dual_port.sv
// Embedded block RAM, single- or true dual-port, configured over AXI4-Lite
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module block_ram_single_dual_port
    import ram_pkg::*;
#(
    parameter bit                    GLOBAL_INIT_NET = 1'b0,
    parameter logic [ARRAY_BITS-1:0] INIT_BITS       = '0
)
(
    input  wire logic                         clk_i,
    input  wire logic                         nrst_i,
    // Memory ports, index 0 is port A, index 1 is port B
    input  wire logic [NPORTS-1:0]            port_clocks_i,
    input  wire logic [NPORTS-1:0]            port_clock_gates_i,
    input  wire logic [NPORTS-1:0]            port_clear_inputs_i,
    input  wire logic [NPORTS-1:0]            port_write_strobes_i,
    input  wire logic [NPORTS-1:0]            port_output_stage_gates_i,
    input  wire logic [NPORTS-1:0][2:0]       port_select_buses_i,
    input  wire logic [NPORTS-1:0][IDX_W-1:0] port_word_indexes_i,
    input  wire logic [NPORTS-1:0][ROW_W-1:0] port_write_words_i,
    output logic      [NPORTS-1:0][ROW_W-1:0] port_read_words_o,
    // AXI4-Lite slave
    input  wire logic [AXI_ADDR_W-1:0]        s_axi_awaddr_i,
    input  wire logic                         s_axi_awvalid_i,
    output logic                              s_axi_awready_o,
    input  wire logic [31:0]                  s_axi_wdata_i,
    input  wire logic [3:0]                   s_axi_wstrb_i,
    input  wire logic                         s_axi_wvalid_i,
    output logic                              s_axi_wready_o,
    output logic [1:0]                        s_axi_bresp_o,
    output logic                              s_axi_bvalid_o,
    input  wire logic                         s_axi_bready_i,
    input  wire logic [AXI_ADDR_W-1:0]        s_axi_araddr_i,
    input  wire logic                         s_axi_arvalid_i,
    output logic                              s_axi_arready_o,
    output logic [31:0]                       s_axi_rdata_o,
    output logic [1:0]                        s_axi_rresp_o,
    output logic                              s_axi_rvalid_o,
    input  wire logic                         s_axi_rready_i
);

    // ------------------------------------------------------------
    // Configuration state
    // ------------------------------------------------------------
    logic [NPORTS-1:0][7:0] port_cfg;
    logic [1:0]             block_cfg;

    wire logic clear_async = block_cfg[F_CLR_ASYNC];
    wire logic single_use  = block_cfg[F_SINGLE];

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    // Address and data are taken together; the master offers both at once
    wire logic       wr_take   = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_bvalid_o;
    wire logic       wr_port_a = s_axi_awaddr_i == OFS_PORT_A;
    wire logic       wr_port_b = s_axi_awaddr_i == OFS_PORT_B;
    wire logic       wr_block  = s_axi_awaddr_i == OFS_BLOCK;
    wire logic       wr_status = s_axi_awaddr_i == OFS_STATUS;
    wire logic       wr_hit    = wr_port_a | wr_port_b | wr_block | wr_status;
    wire logic       wr_lane0  = s_axi_wstrb_i[0];

    assign s_axi_awready_o = wr_take;
    assign s_axi_wready_o  = wr_take;

    // Config registers; all fields live in byte lane 0
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            port_cfg  <= {PORT_CFG_RST, PORT_CFG_RST};
            block_cfg <= BLOCK_CFG_RST;
        end
        else if (wr_take && wr_lane0)
        begin
            if (wr_port_a)
                port_cfg[0] <= s_axi_wdata_i[7:0];
            if (wr_port_b)
                port_cfg[1] <= s_axi_wdata_i[7:0];
            if (wr_block)
                block_cfg   <= s_axi_wdata_i[1:0];
        end
    end

    // Write response; status is read-only so a write there is refused too
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
        end
        else if (wr_take)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= (wr_hit && !wr_status) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready_i)
        begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    wire logic        rd_take = s_axi_arvalid_i & ~s_axi_rvalid_o;
    logic      [31:0] rd_word;
    logic             rd_hit;

    assign s_axi_arready_o = rd_take;

    // Read decode; the status word shows both ports' present read words
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr_i)
            OFS_PORT_A: rd_word = {24'h00_0000, port_cfg[0]};
            OFS_PORT_B: rd_word = {24'h00_0000, port_cfg[1]};
            OFS_BLOCK:  rd_word = {30'h0000_0000, block_cfg};
            OFS_STATUS: rd_word = {7'h00, port_read_words_o[1],
                                   7'h00, port_read_words_o[0]};
            default:    rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_word;
            s_axi_rresp_o  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready_i)
        begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------
    logic [NPORTS-1:0]                mem_en;
    logic [NPORTS-1:0]                mem_we;
    logic [NPORTS-1:0][ROW_IDX_W-1:0] mem_row;
    logic [NPORTS-1:0][ROW_W-1:0]     mem_data;
    logic [NPORTS-1:0][ROW_W-1:0]     mem_mask;
    logic [NPORTS-1:0][ROW_W-1:0]     mem_rdata;

    ram_store #(
        .INIT_BITS (INIT_BITS)
    ) u_store (
        .clk_i   (clk_i),
        .en_i    (mem_en),
        .we_i    (mem_we),
        .row_i   (mem_row),
        .data_i  (mem_data),
        .mask_i  (mem_mask),
        .rdata_o (mem_rdata)
    );

    // The output flops see nrst_i only when the global init net is linked
    // optional global init
    wire logic out_rst_n = GLOBAL_INIT_NET ? nrst_i : 1'b1;

    // ------------------------------------------------------------
    // Port logic, one copy per port
    // ------------------------------------------------------------
    for (genvar g = 0; g < NPORTS; g++)
    begin : g_port
        logic             clk_q;
        logic             acc_q;
        logic             we_q;
        logic [1:0]       code_q;
        logic [1:0]       mode_q;
        logic [2:0]       lo_q;
        logic [ROW_W-1:0] wdata_q;
        logic [ROW_W-1:0] dout;
        logic [ROW_W-1:0] out_reg;
        logic [ROW_W-1:0] next_dout;

        wire logic [1:0] code    = port_cfg[g][F_WIDTH_LO +: 2];
        wire logic [1:0] mode    = port_cfg[g][F_WRMODE_LO +: 2];
        wire logic [2:0] sel_cst = port_cfg[g][F_SEL_LO +: 3];
        wire logic       reg_out = port_cfg[g][F_OUTPUT_PIPELINE_SETTING];
        wire logic [2:0] lo      = port_word_indexes_i[g][2:0];

        // Port B is parked while the block is in single-port use
        // single-port use on port A
        wire logic in_use = (g == 0) || !single_use;

        // rising edge of the port clock
        wire logic port_edge = port_clocks_i[g] & ~clk_q;

        wire logic sel_ok = port_select_buses_i[g] == sel_cst;

        // only while the clock gate is high
        wire logic access = port_edge & port_clock_gates_i[g] & sel_ok & in_use;

        // clear waits for a port edge unless asynchronous style
        wire logic clear_now = port_clear_inputs_i[g] & (clear_async | port_edge);

        // row from the top ten index bits, lanes from the low three
        // each port drives its own index and data
        assign mem_en[g]   = access;
        assign mem_we[g]   = port_write_strobes_i[g];
        assign mem_row[g]  = port_word_indexes_i[g][IDX_W-1 -: ROW_IDX_W];
        assign mem_data[g] = lane_place(code, lo, port_write_words_i[g]);
        assign mem_mask[g] = lane_mask(code, lo);

        // Port clock history; starts high so a clock high at release is no edge
        always_ff @(posedge clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
                clk_q <= 1'b1;
            else
                clk_q <= port_clocks_i[g];
        end

        // Access details held one cycle, until the array's read word is back
        always_ff @(posedge clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                acc_q   <= 1'b0;
                we_q    <= 1'b0;
                code_q  <= WIDTH_9;
                mode_q  <= WR_NORMAL;
                lo_q    <= 3'h0;
                wdata_q <= 9'h000;
            end
            else
            begin
                acc_q <= access;
                if (access)
                begin
                    we_q    <= port_write_strobes_i[g];
                    code_q  <= code;
                    mode_q  <= mode;
                    lo_q    <= lo;
                    wdata_q <= mem_data[g];
                end
            end
        end

        // Output word after an access; an unknown mode code acts as normal
        // output during a write follows the mode
        always_comb
        begin
            next_dout = lane_take(code_q, lo_q, mem_rdata[g]);
            if (we_q)
            begin
                unique case (mode_q)
                    WR_THROUGH: next_dout = lane_take(code_q, lo_q, wdata_q);
                    WR_OLDWORD: next_dout = lane_take(code_q, lo_q, mem_rdata[g]);
                    default:    next_dout = dout;
                endcase
            end
        end

        // Output data and optional pipeline register; clear wins over a load
        // clear never reaches the array
        // own clear and own output stage gate
        always @(posedge clk_i or negedge out_rst_n)
        begin
            if (!out_rst_n)
            begin
                dout    <= 9'h000;
                out_reg <= 9'h000;
            end
            else if (clear_now)
            begin
                dout    <= 9'h000;
                out_reg <= 9'h000;
            end
            else
            begin
                if (acc_q)
                    dout <= next_dout;
                if (port_edge && port_output_stage_gates_i[g])
                    out_reg <= dout;
            end
        end

        // Flops start cleared even when no reset reaches them
        initial
        begin
            dout    = 9'h000;
            out_reg = 9'h000;
        end

        // unregistered or through the output register
        assign port_read_words_o[g] = reg_out ? out_reg : dout;
    end

endmodule

// ===== design/ram_pkg.sv
// Shared constants, field layouts and lane helpers for the block RAM
package ram_pkg;

    // ------------------------------------------------------------
    // Storage geometry
    // ------------------------------------------------------------
    localparam int ARRAY_BITS = 9216;          // Whole storage array
    localparam int ROW_W      = 9;             // Physical row width
    localparam int ROWS       = ARRAY_BITS / ROW_W;
    localparam int IDX_W      = 13;            // Word index width
    localparam int ROW_IDX_W  = 10;            // Row part of the word index
    localparam int NPORTS     = 2;

    // ------------------------------------------------------------
    // Width codes and write/read behaviours
    // ------------------------------------------------------------
    localparam logic [1:0] WIDTH_1 = 2'h0;
    localparam logic [1:0] WIDTH_2 = 2'h1;
    localparam logic [1:0] WIDTH_4 = 2'h2;
    localparam logic [1:0] WIDTH_9 = 2'h3;

    localparam logic [1:0] WR_NORMAL  = 2'h0;  // Output holds during a write
    localparam logic [1:0] WR_THROUGH = 2'h1;  // Output shows new data
    localparam logic [1:0] WR_OLDWORD = 2'h2;  // Output shows old stored word

    // ------------------------------------------------------------
    // Register map (byte addresses) and field positions
    // ------------------------------------------------------------
    localparam int         AXI_ADDR_W   = 8;
    localparam logic [7:0] OFS_PORT_A   = 8'h00;
    localparam logic [7:0] OFS_PORT_B   = 8'h04;
    localparam logic [7:0] OFS_BLOCK    = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;

    localparam int F_WIDTH_LO   = 0;           // Port cfg [1:0] width code
    localparam int F_OUTPUT_PIPELINE_SETTING    = 2;           // Port cfg [2] output pipeline
    localparam int F_WRMODE_LO  = 3;           // Port cfg [4:3] write behaviour
    localparam int F_SEL_LO     = 5;           // Port cfg [7:5] select match
    localparam int F_CLR_ASYNC  = 0;           // Block cfg [0] clear style
    localparam int F_SINGLE     = 1;           // Block cfg [1] single-port use
    localparam int F_RB_SHIFT   = 16;          // Status: port B read word lane

    localparam logic [7:0] PORT_CFG_RST  = 8'h03;  // 9 bits, no reg, normal, 0b000
    localparam logic [1:0] BLOCK_CFG_RST = 2'h0;   // Sync clear, dual-port use

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Lane helpers
    // ------------------------------------------------------------
    // Bits of a row touched by one word of the given width
    function automatic logic [8:0] lane_mask(input logic [1:0] code, input logic [2:0] lo);
        unique case (code)
            WIDTH_1: lane_mask = 9'h001 << lo;
            WIDTH_2: lane_mask = 9'h003 << {lo[2:1], 1'b0};
            WIDTH_4: lane_mask = 9'h00F << {lo[2], 2'h0};
            default: lane_mask = 9'h1FF;
        endcase
    endfunction

    // Word moved to its place inside a row
    function automatic logic [8:0] lane_place(input logic [1:0] code, input logic [2:0] lo,
                                              input logic [8:0] d);
        unique case (code)
            WIDTH_1: lane_place = {8'h00, d[0]} << lo;
            WIDTH_2: lane_place = {7'h00, d[1:0]} << {lo[2:1], 1'b0};
            WIDTH_4: lane_place = {5'h00, d[3:0]} << {lo[2], 2'h0};
            default: lane_place = d;
        endcase
    endfunction

    // Word taken out of a row, zero above its width
    function automatic logic [8:0] lane_take(input logic [1:0] code, input logic [2:0] lo,
                                             input logic [8:0] w);
        unique case (code)
            WIDTH_1: lane_take = {8'h00, w[lo]};
            WIDTH_2: lane_take = {7'h00, w[{lo[2:1], 1'b0} +: 2]};
            WIDTH_4: lane_take = {5'h00, w[{lo[2], 2'h0} +: 4]};
            default: lane_take = w;
        endcase
    endfunction

endpackage

// ===== design/ram_store.sv
// Two-port storage array with bit-lane writes and registered read data
`timescale 1ns/1ps
module ram_store
    import ram_pkg::*;
#(
    parameter logic [ARRAY_BITS-1:0] INIT_BITS = '0
)
(
    input  wire logic                               clk_i,
    input  wire logic [NPORTS-1:0]                  en_i,
    input  wire logic [NPORTS-1:0]                  we_i,
    input  wire logic [NPORTS-1:0][ROW_IDX_W-1:0]   row_i,
    input  wire logic [NPORTS-1:0][ROW_W-1:0]       data_i,
    input  wire logic [NPORTS-1:0][ROW_W-1:0]       mask_i,
    output logic      [NPORTS-1:0][ROW_W-1:0]       rdata_o
);

    logic [ROW_W-1:0] cells [ROWS];

    // ------------------------------------------------------------
    // Power-on contents
    // ------------------------------------------------------------
    // Each bit starts at its own configured value
    initial
    begin
        for (int r = 0; r < ROWS; r++)
        begin
            cells[r] = INIT_BITS[r*ROW_W +: ROW_W];
        end
        rdata_o = '0;
    end

    // ------------------------------------------------------------
    // Access
    // ------------------------------------------------------------
    // Per-bit writes so two ports on one row only clash on shared bits;
    // the read register always catches the word as it was before the edge
    always @(posedge clk_i)
    begin
        for (int p = 0; p < NPORTS; p++)
        begin
            if (en_i[p])
            begin
                rdata_o[p] <= cells[row_i[p]];
                for (int b = 0; b < ROW_W; b++)
                begin
                    if (we_i[p] && mask_i[p][b])
                    begin
                        cells[row_i[p]][b] <= data_i[p][b];
                    end
                end
            end
        end
    end

endmodule

// ===== tb/block_ram_single_dual_port_chk.sv
// Port-level assertions for the block RAM
`timescale 1ns/1ps
module block_ram_single_dual_port_chk
    import ram_pkg::*;
(
    input wire logic                         clk_i,
    input wire logic                         nrst_i,
    input wire logic [NPORTS-1:0]            port_clocks_i,
    input wire logic [NPORTS-1:0]            port_clear_inputs_i,
    input wire logic [NPORTS-1:0][ROW_W-1:0] port_read_words_o,
    input wire logic [AXI_ADDR_W-1:0]        s_axi_awaddr_i,
    input wire logic                         s_axi_awvalid_i,
    input wire logic                         s_axi_awready_o,
    input wire logic                         s_axi_wvalid_i,
    input wire logic [1:0]                   s_axi_bresp_o,
    input wire logic                         s_axi_bvalid_o,
    input wire logic                         s_axi_bready_i,
    input wire logic                         s_axi_arvalid_i,
    input wire logic                         s_axi_rvalid_o,
    input wire logic [31:0]                  s_axi_rdata_o,
    input wire logic                         s_axi_rready_i
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // Answer one cycle after taking
    property p_wr_answer;
        s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o |=> s_axi_bvalid_o;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_wr_hold;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
    // One write at a time
    property p_wr_busy;
        s_axi_bvalid_o |-> !s_axi_awready_o;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write taken while busy");
    property p_rd_answer;
        s_axi_arvalid_i && !s_axi_rvalid_o |=> s_axi_rvalid_o;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_rd_hold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
    property p_status_err;
        s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o && s_axi_awaddr_i == OFS_STATUS
            |=> s_axi_bresp_o == RESP_SLVERR;
    endproperty
    a_status_err: assert property (p_status_err) else $error("status write accepted");
    // No edge, clear or write: word holds
    property p_quiet;
        (!port_clocks_i[0] && !port_clear_inputs_i[0] && !s_axi_wvalid_i)[*3]
            |=> $stable(port_read_words_o[0]);
    endproperty
    a_quiet: assert property (p_quiet) else $error("read word moved without edge");
    // Sync clear at a port edge
    property p_clear;
        port_clear_inputs_i[0] && $rose(port_clocks_i[0]) && $past(nrst_i)
            |=> port_read_words_o[0] == 9'h000;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not empty output");
endmodule

bind block_ram_single_dual_port block_ram_single_dual_port_chk i_chk (.*);

// ===== tb/block_ram_single_dual_port_test.sv
// Self-checking bench for the block RAM
`timescale 1ns/1ps
module block_ram_single_dual_port_test;
    import ram_pkg::*;

    logic                         clk_i, nrst_i;
    logic [NPORTS-1:0]            pclk, gate, clr, we, og;
    logic [NPORTS-1:0][2:0]       sel;
    logic [NPORTS-1:0][IDX_W-1:0] idx;
    logic [NPORTS-1:0][ROW_W-1:0] wd, rw;
    logic [7:0]                   awaddr, araddr;
    logic [31:0]                  wdata, rdata, d;
    logic [1:0]                   bresp, rresp, r;
    logic                         awvalid, awready, wvalid, wready, bvalid, bready;
    logic                         arvalid, arready, rvalid, rready;
    int                           bad_count, checks;

    ram_user_model u_m (.clk_i(clk_i), .pclk_o(pclk), .gate_o(gate), .clr_o(clr), .we_o(we),
        .og_o(og), .sel_o(sel), .idx_o(idx), .wd_o(wd));

    block_ram_single_dual_port i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .port_clocks_i(pclk),
        .port_clock_gates_i(gate), .port_clear_inputs_i(clr), .port_write_strobes_i(we),
        .port_output_stage_gates_i(og), .port_select_buses_i(sel), .port_word_indexes_i(idx),
        .port_write_words_i(wd), .port_read_words_o(rw), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready));

    // 100 MHz clock
    initial
    begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic conclude(input int extra);
        bad_count += extra;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded handshake wait
    task automatic hold_until(ref logic s);
        int n;
        for (n = 0; n < 50 && s !== 1'h1; n++)
            @(posedge clk_i);
        if (s !== 1'h1)
            conclude(1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        hold_until(awready);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        bready <= 1'h1;
        hold_until(bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'h1;
        hold_until(arready);
        arvalid <= 1'h0;
        rready <= 1'h1;
        hold_until(rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask

    task automatic setcfg(input logic [7:0] a, input logic [7:0] v);
        wr(a, {24'h0, v});
        cmp(32'(r), 32'(RESP_OKAY));
    endtask

    task automatic t_defaults();
        rd(OFS_PORT_A);
        cmp(d, {24'h0, PORT_CFG_RST});
        rd(OFS_PORT_B);
        cmp(d, {24'h0, PORT_CFG_RST});
        rd(OFS_BLOCK);
        cmp(d, 32'h0000_0000);
        rd(8'h10);
        cmp({d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(OFS_STATUS, 32'h0000_00FF);
        cmp(32'(r), 32'(RESP_SLVERR));
        $display("defaults test done");
    endtask

    // Ones into lane 5 per width; port B reads the row
    task automatic t_widths();
        logic [8:0] am [4] = '{9'h001, 9'h003, 9'h00F, 9'h1FF};
        logic [8:0] lm [4] = '{9'h020, 9'h030, 9'h0F0, 9'h1FF};
        for (int c = 0; c < 4; c++)
        begin
            setcfg(OFS_PORT_A, 8'(c));
            u_m.op(0, 1, 1, 0, {10'(c + 1), 3'h5}, 9'h1FF, 3'h0);
            u_m.op(0, 0, 1, 0, {10'(c + 1), 3'h5}, 9'h000, 3'h0);
            cmp(32'(rw[0]), 32'(am[c]));
            u_m.op(1, 0, 1, 0, {10'(c + 1), 3'h0}, 9'h000, 3'h0);
            cmp(32'(rw[1]), 32'(lm[c]));
        end
        $display("widths test done");
    endtask

    // Output 0 first tells normal from old word
    task automatic t_modes();
        logic [8:0] old;
        old = 9'h0AA;
        u_m.op(1, 1, 1, 0, 13'h00A0, old, 3'h0);
        for (int m = 0; m < 3; m++)
        begin
            setcfg(OFS_PORT_A, 8'(8'h03 | (m << 3)));
            u_m.op(0, 0, 1, 0, 13'h1FF8, 9'h000, 3'h0);
            u_m.op(0, 1, 1, 0, 13'h00A0, 9'(9'h100 + m), 3'h0);
            cmp(32'(rw[0]), m == 0 ? 32'h0 : m == 1 ? 32'(9'h100 + m) : 32'(old));
            old = 9'(9'h100 + m);
        end
        $display("modes test done");
    endtask

    task automatic t_select_clear();
        setcfg(OFS_PORT_A, 8'hA3);
        u_m.op(0, 1, 1, 0, 13'h00F0, 9'h155, 3'h4);
        u_m.op(0, 1, 0, 0, 13'h00F0, 9'h155, 3'h5);
        u_m.op(0, 0, 1, 0, 13'h00F0, 9'h000, 3'h5);
        cmp(32'(rw[0]), 32'h0000_0000);
        u_m.op(0, 1, 1, 0, 13'h00F0, 9'h155, 3'h5);
        u_m.op(0, 0, 1, 0, 13'h00F0, 9'h000, 3'h5);
        cmp(32'(rw[0]), 32'h0000_0155);
        u_m.op(0, 0, 0, 1, 13'h00F0, 9'h000, 3'h5);
        cmp(32'(rw[0]), 32'h0000_0000);
        u_m.op(0, 0, 1, 0, 13'h00F0, 9'h000, 3'h5);
        cmp(32'(rw[0]), 32'h0000_0155);
        $display("select test done");
    endtask

    task automatic t_regout_single();
        setcfg(OFS_PORT_A, 8'hA7);
        u_m.op(0, 0, 1, 0, 13'h1FF8, 9'h000, 3'h5);
        u_m.op(0, 0, 1, 0, 13'h1FF8, 9'h000, 3'h5);
        u_m.op(0, 0, 1, 0, 13'h00F0, 9'h000, 3'h5);
        cmp(32'(rw[0]), 32'h0000_0000);
        u_m.op(0, 0, 1, 0, 13'h00F0, 9'h000, 3'h5);
        cmp(32'(rw[0]), 32'h0000_0155);
        setcfg(OFS_BLOCK, 8'h02);
        u_m.op(1, 1, 1, 0, 13'h0140, 9'h1FF, 3'h0);
        setcfg(OFS_BLOCK, 8'h00);
        u_m.op(1, 0, 1, 0, 13'h0140, 9'h000, 3'h0);
        cmp(32'(rw[1]), 32'h0000_0000);
        $display("regout test done");
    endtask

    // Main sequence
    initial
    begin
        nrst_i = 1'h0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        bad_count = 0;
        checks = 0;
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'h1;
        t_defaults();
        t_widths();
        t_modes();
        t_select_clear();
        t_regout_single();
        conclude(0);
    end
endmodule

// ===== tb/ram_user_model.sv
// Fabric-side user logic that drives both memory ports
`timescale 1ns/1ps
module ram_user_model
    import ram_pkg::*;
(
    input  wire logic                         clk_i,
    output logic      [NPORTS-1:0]            pclk_o,
    output logic      [NPORTS-1:0]            gate_o,
    output logic      [NPORTS-1:0]            clr_o,
    output logic      [NPORTS-1:0]            we_o,
    output logic      [NPORTS-1:0]            og_o,
    output logic      [NPORTS-1:0][2:0]       sel_o,
    output logic      [NPORTS-1:0][IDX_W-1:0] idx_o,
    output logic      [NPORTS-1:0][ROW_W-1:0] wd_o
);
    // Quiet ports at power-up
    initial
    begin
        {pclk_o, gate_o, clr_o, we_o, og_o, sel_o, idx_o, wd_o} = '0;
    end

    // One port edge, then index and data are scrambled
    // strobe picks write
    task automatic op(input int p, w, g, c, input logic [12:0] ix, input logic [8:0] d,
                      input logic [2:0] s);
        @(posedge clk_i);
        pclk_o[p] <= 1'h1;
        gate_o[p] <= g[0];
        clr_o[p] <= c[0];
        we_o[p] <= w[0];
        og_o[p] <= 1'h1;
        sel_o[p] <= s;
        idx_o[p] <= ix;
        wd_o[p] <= d;
        @(posedge clk_i);
        pclk_o[p] <= 1'h0;
        gate_o[p] <= 1'h0;
        clr_o[p] <= 1'h0;
        og_o[p] <= 1'h0;
        idx_o[p] <= ~ix;
        wd_o[p] <= ~d;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
endmodule
